// [design/tpi_top.sv]
// Interrupt flags, pin triggers and handler entry/return sequencing.
// Assumes timer strobes and core signals synchronous to clk; pins are synchronised here.
`default_nettype none
`include "tpi_cfg.svh"
// Behaviour
// - Set compare flag bit 6 when counter1 matches compare value.
// - Set capture flag bit 3 when capture value is transferred.
// - Set counter0 overflow flag bit 1 on overflow.
// - Vectoring to a handler clears that handler's own flag.
// - Writing one clears a timer flag; zero leaves it.
// - Timer request needs global enable, source enable and flag together.
// - Flag register bits 5, 4, 2, 0 read zero.
// - Pins trigger even when driven as outputs by the device.
// - Each pin triggers on falling edge, rising edge or low level.
// - Level mode requests continuously while pin stays low.
// - Vector executes no sooner than four cycles after flag set.
// - Entry pushes two-byte program counter, stack pointer minus two.
// - Vector relative jump takes two cycles.
// - Multi-cycle instruction completes before interrupt is served.
// - Return takes four cycles, pops counter, pointer plus two, sets enable.
// - One instruction runs after return before next pending interrupt.
// - Sense code 00 low, 01 reserved, 10 falling, 11 rising.
// - Accepting an interrupt clears the global enable.
// - Flag raised while disabled stays set until enabled or cleared.
// - Pin is sampled before edge detection.
module tpi_top
   import tpi_pkg::*;
#(
   parameter int CNT_W = 16
) (
   input wire logic clk, // 100 MHz clock
   input wire logic rst_n, // Async reset, active low
   input wire logic [3:0] reg_addr, // Register address
   input wire logic [7:0] reg_wdata, // Write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   output logic [7:0] reg_rdata, // Read data, cycle after strobe
   input wire logic [CNT_W-1:0] counter1, // Counter1 value
   input wire logic [CNT_W-1:0] compare_value_reg, // Compare value
   input wire logic capture_load, // Capture register load strobe
   input wire logic counter0_ovf, // Counter0 overflow strobe
   input wire logic ext_irq_pin_a, // Pin level, read even as output
   input wire logic ext_irq_pin_b, // Pin level, read even as output
   input wire logic insn_done, // Core at an instruction boundary
   input wire logic gie_set, // Software sets global enable
   input wire logic gie_clr, // Software clears global enable
   input wire logic reti, // Core decoded a return
   input wire logic [15:0] pc_in, // Program counter to save
   input wire logic [15:0] pop_data, // Counter value popped from stack
   output logic [15:0] stack_ptr, // Stack pointer
   output logic [15:0] push_data, // Counter value to push
   output logic [15:0] pc_out, // Vector or return address
   output logic pc_load, // Load pc_out into counter
   output tpi_core_t core_ctl, // Push, pop and vector
   output logic cpu_hold, // Core stalled by sequencer
   output logic gie // Global interrupt enable
);
   logic rst_s1_r, rst_s2_r;
   logic srst_n;
   // Reset release through two flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end
   assign srst_n = rst_s2_r;

   logic [7:0] flags_r, flags_nxt, irq_en_r, pin_en_r, sense_r, pin_flags_r, pin_flags_nxt;
   logic [7:0] rdata_nxt;
   logic [1:0] pin_s1_r, pin_s2_r, pin_old_r;
   logic gie_r, gie_nxt, cmp_eq_old_r;
   tpi_state_t state_r, state_nxt;
   logic [2:0] cnt_r, cnt_nxt, vec_r, vec_nxt;
   logic [15:0] sp_r, sp_nxt, pc_save_r;
   tpi_evt_t evt;

   // Compare match counts once per new equality, capture and overflow are strobes
   wire cmp_eq = (counter1 == compare_value_reg);
   assign evt.cmp_match = cmp_eq & ~cmp_eq_old_r;
   assign evt.capture = capture_load;
   assign evt.ovf0 = counter0_ovf;

   // Register decode
   wire wr_flags = reg_wr && reg_addr == `TPI_OFS_FLAGS;
   wire wr_irq_en = reg_wr && reg_addr == `TPI_OFS_IRQ_EN;
   wire wr_pin_en = reg_wr && reg_addr == `TPI_OFS_PIN_EN;
   wire wr_sense = reg_wr && reg_addr == `TPI_OFS_SENSE;
   wire wr_pin_flags = reg_wr && reg_addr == `TPI_OFS_PIN_FLAGS;
   wire [7:0] flag_mask = 8'h4a; // Implemented bits 6, 3, 1

   // Pin detection on synchronised samples
   wire [1:0] pin_now = pin_s2_r;
   wire [1:0] sense_hi = {sense_r[3], sense_r[1]};
   wire [1:0] sense_lo = {sense_r[2], sense_r[0]};
   wire [1:0] fall = pin_old_r & ~pin_now;
   wire [1:0] rise = ~pin_old_r & pin_now;
   wire [1:0] edge_hit = sense_hi & ((sense_lo & rise) | (~sense_lo & fall));
   wire [1:0] level_mode = ~sense_hi & ~sense_lo; // 01 reserved: no trigger
   wire [1:0] pin_en = {pin_en_r[`TPI_BIT_PIN_B], pin_en_r[`TPI_BIT_PIN_A]};
   wire [1:0] pin_fl = {pin_flags_r[`TPI_BIT_PIN_B], pin_flags_r[`TPI_BIT_PIN_A]};
   wire [1:0] pin_req = pin_en & ((level_mode & ~pin_now) | (~level_mode & pin_fl));

   // Pending timer sources gated by own enable
   wire cmp_req = flags_r[`TPI_BIT_CMP] & irq_en_r[`TPI_BIT_CMP];
   wire cap_req = flags_r[`TPI_BIT_CAP] & irq_en_r[`TPI_BIT_CAP];
   wire ovf_req = flags_r[`TPI_BIT_OVF0] & irq_en_r[`TPI_BIT_OVF0];
   wire any_req = |{pin_req, cmp_req, cap_req, ovf_req};
   // Accept only at instruction end with global enable
   wire accept = (state_r == TPI_RUN) && gie_r && any_req && insn_done;
   // Priority by vector number
   wire [2:0] pick = pin_req[0] ? `TPI_VEC_PIN_A : pin_req[1] ? `TPI_VEC_PIN_B :
                     cap_req ? `TPI_VEC_CAP : cmp_req ? `TPI_VEC_CMP : `TPI_VEC_OVF0;
   wire vectoring = (state_r == TPI_ENTRY) && cnt_r == 3'(`TPI_ENTRY_CYC - 1);

   // Flag update: hardware set wins over any clear
   always_comb begin
      flags_nxt = flags_r;
      if (wr_flags) flags_nxt = flags_nxt & ~(reg_wdata & flag_mask);
      if (vectoring && vec_r == `TPI_VEC_CMP) flags_nxt[`TPI_BIT_CMP] = 1'b0;
      if (vectoring && vec_r == `TPI_VEC_CAP) flags_nxt[`TPI_BIT_CAP] = 1'b0;
      if (vectoring && vec_r == `TPI_VEC_OVF0) flags_nxt[`TPI_BIT_OVF0] = 1'b0;
      if (evt.cmp_match) flags_nxt[`TPI_BIT_CMP] = 1'b1;
      if (evt.capture) flags_nxt[`TPI_BIT_CAP] = 1'b1;
      if (evt.ovf0) flags_nxt[`TPI_BIT_OVF0] = 1'b1;
      pin_flags_nxt = pin_flags_r;
      if (wr_pin_flags) pin_flags_nxt = pin_flags_nxt & ~reg_wdata;
      if (vectoring && vec_r == `TPI_VEC_PIN_A) pin_flags_nxt[`TPI_BIT_PIN_A] = 1'b0;
      if (vectoring && vec_r == `TPI_VEC_PIN_B) pin_flags_nxt[`TPI_BIT_PIN_B] = 1'b0;
      if (edge_hit[0]) pin_flags_nxt[`TPI_BIT_PIN_A] = 1'b1;
      if (edge_hit[1]) pin_flags_nxt[`TPI_BIT_PIN_B] = 1'b1;
      if (level_mode[0]) pin_flags_nxt[`TPI_BIT_PIN_A] = 1'b0;
      if (level_mode[1]) pin_flags_nxt[`TPI_BIT_PIN_B] = 1'b0;
      pin_flags_nxt = pin_flags_nxt & 8'hc0;
   end

   // Entry and return sequencer
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      vec_nxt = vec_r;
      sp_nxt = sp_r;
      gie_nxt = gie_r;
      if (gie_set) gie_nxt = 1'b1;
      if (gie_clr) gie_nxt = 1'b0;
      case (state_r)
         TPI_RUN: begin
            cnt_nxt = 3'h0;
            if (accept) begin
               state_nxt = TPI_ENTRY;
               vec_nxt = pick;
               gie_nxt = 1'b0;
            end else if (reti && insn_done) begin
               state_nxt = TPI_RET;
            end
         end
         TPI_ENTRY: begin // Four cycles before the vector runs
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == 3'h1) sp_nxt = sp_r - 16'h0002;
            if (vectoring) begin
               state_nxt = TPI_JUMP;
               cnt_nxt = 3'h0;
            end
         end
         TPI_JUMP: begin // Relative jump at the vector
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == 3'(`TPI_JUMP_CYC - 1)) state_nxt = TPI_RUN;
         end
         TPI_RET: begin // Pop, pointer up, enable on
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == 3'h1) sp_nxt = sp_r + 16'h0002;
            if (cnt_r == 3'(`TPI_RETURN_CYC - 1)) begin
               gie_nxt = 1'b1;
               state_nxt = TPI_ONE;
            end
         end
         TPI_ONE: begin // One instruction before next service
            if (insn_done) state_nxt = TPI_RUN;
         end
         default: state_nxt = TPI_RUN;
      endcase
   end

   // Read mux
   assign rdata_nxt = (reg_addr == `TPI_OFS_FLAGS) ? (flags_r & flag_mask) :
                      (reg_addr == `TPI_OFS_IRQ_EN) ? irq_en_r :
                      (reg_addr == `TPI_OFS_PIN_EN) ? pin_en_r :
                      (reg_addr == `TPI_OFS_SENSE) ? sense_r :
                      (reg_addr == `TPI_OFS_PIN_FLAGS) ? pin_flags_r :
                      (reg_addr == `TPI_OFS_STATUS) ? {gie_r, 4'h0, state_r} : 8'h00;

   // Pin synchroniser, first stage read only by second
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         pin_s1_r <= 2'h3;
         pin_s2_r <= 2'h3;
         pin_old_r <= 2'h3;
      end else begin
         pin_s1_r <= {ext_irq_pin_b, ext_irq_pin_a};
         pin_s2_r <= pin_s1_r;
         pin_old_r <= pin_s2_r;
      end
   end

   // Flags and configuration registers
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         flags_r <= `TPI_FLAGS_RST;
         pin_flags_r <= `TPI_FLAGS_RST;
         irq_en_r <= `TPI_EN_RST;
         pin_en_r <= `TPI_EN_RST;
         sense_r <= `TPI_EN_RST;
         cmp_eq_old_r <= 1'b0;
         reg_rdata <= 8'h00;
      end else begin
         flags_r <= flags_nxt;
         pin_flags_r <= pin_flags_nxt;
         cmp_eq_old_r <= cmp_eq;
         if (wr_irq_en) irq_en_r <= reg_wdata & flag_mask;
         if (wr_pin_en) pin_en_r <= reg_wdata & 8'hc0;
         if (wr_sense) sense_r <= reg_wdata & 8'h0f;
         reg_rdata <= reg_rd ? rdata_nxt : 8'h00;
      end
   end

   // Sequencer registers
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         state_r <= TPI_RUN;
         cnt_r <= 3'h0;
         vec_r <= 3'h0;
         sp_r <= 16'h0000;
         gie_r <= 1'b0;
         pc_save_r <= 16'h0000;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         vec_r <= vec_nxt;
         sp_r <= sp_nxt;
         gie_r <= gie_nxt;
         if (accept) pc_save_r <= pc_in;
      end
   end

   // Core side outputs
   assign core_ctl.push = (state_r == TPI_ENTRY) && cnt_r == 3'h1;
   assign core_ctl.pop = (state_r == TPI_RET) && cnt_r == 3'h1;
   assign core_ctl.vector = vec_r;
   assign push_data = pc_save_r;
   assign pc_load = vectoring || (state_r == TPI_RET && cnt_r == 3'(`TPI_RETURN_CYC - 1));
   assign pc_out = (state_r == TPI_RET) ? pop_data : {13'h0000, vec_r};
   assign cpu_hold = (state_r == TPI_ENTRY) || (state_r == TPI_JUMP) || (state_r == TPI_RET);
   assign stack_ptr = sp_r;
   assign gie = gie_r;
endmodule
`default_nettype wire

// [design/tpi_cfg.svh]
// Offsets, field positions, reset values and timing counts of the interrupt block.
// Assumes inclusion by the design top and by the bench files.
`ifndef TPI_CFG_SVH
`define TPI_CFG_SVH
// Register offsets on the plain register port
`define TPI_OFS_FLAGS 4'h0
`define TPI_OFS_IRQ_EN 4'h1
`define TPI_OFS_PIN_EN 4'h2
`define TPI_OFS_SENSE 4'h3
`define TPI_OFS_PIN_FLAGS 4'h4
`define TPI_OFS_STATUS 4'h5
// Timer flag bit positions
`define TPI_BIT_CMP 6
`define TPI_BIT_CAP 3
`define TPI_BIT_OVF0 1
`define TPI_FLAGS_RST 8'h00
`define TPI_EN_RST 8'h00
// Pin enable and pin flag positions
`define TPI_BIT_PIN_B 7
`define TPI_BIT_PIN_A 6
// Sense codes
`define TPI_SENSE_LOW 2'h0
`define TPI_SENSE_FALL 2'h2
`define TPI_SENSE_RISE 2'h3
// Vector numbers
`define TPI_VEC_PIN_A 3'h1
`define TPI_VEC_PIN_B 3'h2
`define TPI_VEC_CAP 3'h3
`define TPI_VEC_CMP 3'h4
`define TPI_VEC_OVF0 3'h6
// Cycle counts
`define TPI_ENTRY_CYC 4
`define TPI_RETURN_CYC 4
`define TPI_JUMP_CYC 2
`endif

// [design/tpi_pkg.sv]
// Types shared by the timer and pin interrupt logic.
// Assumes the configuration header sits beside it.
`default_nettype none
package tpi_pkg;
   // Sequencer states
   typedef enum logic [2:0] {
      TPI_RUN   = 3'b000,
      TPI_ENTRY = 3'b001,
      TPI_JUMP  = 3'b010,
      TPI_RET   = 3'b011,
      TPI_ONE   = 3'b100
   } tpi_state_t;
   // Timer event strobes from the counters
   typedef struct packed {
      logic cmp_match;
      logic capture;
      logic ovf0;
   } tpi_evt_t;
   // Requests to the core stack path
   typedef struct packed {
      logic push;
      logic pop;
      logic [2:0] vector;
   } tpi_core_t;
endpackage
`default_nettype wire

// [tb/tpi_props.sv]
// Port-level checks of handler entry, return and register reads.
// Assumes a bind onto tpi_top and a single clock domain.
`default_nettype none
`include "tpi_cfg.svh"
module tpi_props
   import tpi_pkg::*;
(
   input wire logic clk, // Clock
   input wire logic rst_n, // Reset, active low
   input wire logic [3:0] reg_addr, // Address
   input wire logic reg_rd, // Read strobe
   input wire logic [7:0] reg_rdata, // Read data
   input wire logic insn_done, // Boundary
   input wire logic reti, // Return
   input wire logic [15:0] pop_data, // Popped counter
   input wire logic [15:0] stack_ptr, // Stack pointer
   input wire logic [15:0] pc_out, // Load address
   input wire logic pc_load, // Load strobe
   input wire tpi_core_t core_ctl, // Push, pop, vector
   input wire logic cpu_hold, // Stall
   input wire logic gie, // Global enable
   input wire logic [15:0] push_data, // Counter value pushed
   input wire logic [15:0] pc_in // Counter value from the core
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Steps after a push or a pop
   sequence entry_tail_s;
      ##2 pc_load ##1 cpu_hold [*2];
   endsequence
   sequence ret_tail_s;
      ##2 (pc_load && pc_out == pop_data) ##1 gie;
   endsequence
   // Relations on the register read port and the core side
   flag_rsv_a: assert property ($past(reg_rd) && $past(reg_addr) == `TPI_OFS_FLAGS |->
      (reg_rdata & 8'h35) == 8'h00) else $error("reserved flag bits read nonzero");
   entry_hold_a: assert property (core_ctl.push |-> cpu_hold && !gie)
      else $error("push without stall or with enable set");
   entry_time_a: assert property (core_ctl.push |-> entry_tail_s)
      else $error("entry steps out of time");
   entry_gate_a: assert property (core_ctl.push |-> $past(insn_done, 2))
      else $error("entry began mid instruction");
   push_save_a: assert property (core_ctl.push |-> push_data == $past(pc_in, 2))
      else $error("pushed counter differs from counter at accept");
   push_sp_a: assert property (core_ctl.push |=> stack_ptr == $past(stack_ptr) - 16'h0002)
      else $error("stack pointer not lowered by two");
   pop_sp_a: assert property (core_ctl.pop |=> stack_ptr == $past(stack_ptr) + 16'h0002)
      else $error("stack pointer not raised by two");
   ret_time_a: assert property (core_ctl.pop |-> ret_tail_s)
      else $error("return steps out of time");
   ret_gate_a: assert property (core_ctl.pop |-> $past(reti, 2) && $past(insn_done, 2))
      else $error("pop without accepted return");
   ret_gap_a: assert property (core_ctl.pop |=> !core_ctl.push [*5])
      else $error("entry too soon after return");
endmodule
`default_nettype wire

// [tb/tpi_core_model.sv]
// Behavioural core: instruction boundaries, program counter and stack memory.
// Assumes the interrupt block's core-side ports and one clock.
`default_nettype none
module tpi_core_model
   import tpi_pkg::*;
(
   input wire logic clk, // Clock
   input wire logic rst_n, // Reset, active low
   input wire logic slow, // Three-cycle instructions
   input wire logic cpu_hold, // Stall
   input wire logic pc_load, // Load strobe
   input wire logic [15:0] pc_out, // Load address
   input wire logic [15:0] stack_ptr, // Stack pointer
   input wire logic [15:0] push_data, // Pushed counter
   input wire tpi_core_t core_ctl, // Push, pop
   output logic insn_done, // Boundary
   output var logic [15:0] pc_in, // Program counter
   output logic [15:0] pop_data // Top of stack
);
   logic [15:0] stk_r [0:255];
   logic [7:0] top_r;
   logic [1:0] cnt_r;
   // Boundaries come every unstalled cycle, or every third in slow mode
   assign insn_done = !cpu_hold && (!slow || cnt_r == 2'h2);
   assign pop_data = stk_r[top_r];
   // Stack and counter upkeep
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pc_in <= 16'h0100;
         cnt_r <= 2'h0;
         top_r <= 8'h00;
      end else begin
         if (core_ctl.push) begin
            stk_r[stack_ptr[7:0]] <= push_data;
            top_r <= stack_ptr[7:0];
         end
         if (pc_load) pc_in <= pc_out;
         else if (insn_done) pc_in <= pc_in + 16'h0001;
         cnt_r <= (cpu_hold || insn_done) ? 2'h0 : cnt_r + 2'h1;
      end
   end
endmodule
`default_nettype wire

// [tb/timer_and_pin_interrupt_logic_tb_top.sv]
// Self-checking bench of the timer and pin interrupt block.
// Assumes tpi_top, the core model and the checker beside it.
`default_nettype none
`include "tpi_cfg.svh"
module timer_and_pin_interrupt_logic_tb_top
   import tpi_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, reg_wr, reg_rd, capture_load, counter0_ovf, gie_set, gie_clr, reti, slow, insn_done;
   logic pc_load, cpu_hold, gie, pe;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, rv, ef;
   logic [15:0] counter1, compare_value_reg, pc_in, pop_data, stack_ptr, push_data, pc_out, lf;
   logic [1:0] pin;
   logic [2:0] v;
   tpi_core_t core_ctl;
   int n_errors = 0, checks_done = 0, n, i, s, p, e;
   logic [7:0] en_t [3] = '{8'h40, 8'h08, 8'h02};
   logic [2:0] ev_t [3] = '{3'b001, 3'b100, 3'b010};
   logic [2:0] vec_t [3] = '{`TPI_VEC_CMP, `TPI_VEC_CAP, `TPI_VEC_OVF0};
   tpi_top i_dut(.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .counter1(counter1), .compare_value_reg(compare_value_reg),
      .capture_load(capture_load), .counter0_ovf(counter0_ovf), .ext_irq_pin_a(pin[0]), .ext_irq_pin_b(pin[1]),
      .insn_done(insn_done), .gie_set(gie_set), .gie_clr(gie_clr), .reti(reti), .pc_in(pc_in),
      .pop_data(pop_data), .stack_ptr(stack_ptr), .push_data(push_data), .pc_out(pc_out), .pc_load(pc_load),
      .core_ctl(core_ctl), .cpu_hold(cpu_hold), .gie(gie));
   tpi_core_model i_core(.clk(clk), .rst_n(rst_n), .slow(slow), .cpu_hold(cpu_hold), .pc_load(pc_load),
      .pc_out(pc_out), .stack_ptr(stack_ptr), .push_data(push_data), .core_ctl(core_ctl),
      .insn_done(insn_done), .pc_in(pc_in), .pop_data(pop_data));
   function automatic logic [15:0] lfsr_next(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
      @(posedge clk); reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk); reg_addr <= a; reg_rd <= 1'b1;
      @(posedge clk); reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // Strobes: global clear, global set, capture, overflow, compare
   task automatic ev(input logic [4:0] m);
      @(posedge clk); gie_clr <= m[4]; gie_set <= m[3]; capture_load <= m[2]; counter0_ovf <= m[1];
      counter1 <= m[0] ? 16'h0005 : 16'h0006;
      @(posedge clk); gie_clr <= 0; gie_set <= 0; capture_load <= 0; counter0_ovf <= 0; counter1 <= 16'h0006;
   endtask
   task automatic wait_vec();
      n = 0;
      while (n < 60) begin
         @(posedge clk); #1 n++;
         if (pc_load === 1'b1) break;
      end
      v = core_ctl.vector;
   endtask
   task automatic ret_seq();
      @(posedge clk); reti <= 1'b1;
      wait_vec();
      reti <= 1'b0;
      @(posedge clk); #1 chk(gie, 1);
      chk(stack_ptr, 16'h0000);
   endtask
   task automatic close_out();
      $display("errors=%0d checks=%0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Clock and watchdog
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   initial begin
      #500000 n_errors++;
      close_out();
   end
   // Main sequence
   initial begin
      {rst_n, reg_wr, reg_rd, capture_load, counter0_ovf, gie_set, gie_clr, reti, slow} = '0;
      reg_addr = 4'h0; reg_wdata = 8'h00; counter1 = 16'h0006; compare_value_reg = 16'h0005; pin = 2'b11;
      lf = 16'd7561;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      for (i = 0; i < 6; i++) begin rd(4'(i), rv); chk(rv, 0); end
      rd(4'hf, rv); chk(rv, 0);
      wr(`TPI_OFS_IRQ_EN, 8'hff); rd(`TPI_OFS_IRQ_EN, rv); chk(rv, 8'h4a);
      wr(`TPI_OFS_IRQ_EN, 8'h00); ev(5'b01111); wait_vec(); chk(n, 60);
      rd(`TPI_OFS_FLAGS, rv); chk(rv, 8'h4a);
      wr(`TPI_OFS_FLAGS, 8'h00); rd(`TPI_OFS_FLAGS, rv); chk(rv, 8'h4a);
      wr(`TPI_OFS_FLAGS, 8'hff); rd(`TPI_OFS_FLAGS, rv); chk(rv, 8'h00);
      for (i = 0; i < 3; i++) begin
         slow <= (i == 1);
         wr(`TPI_OFS_IRQ_EN, en_t[i]); ev({2'b01, ev_t[i]}); wait_vec();
         chk(v, vec_t[i]);
         chk(pc_out, {13'h0000, vec_t[i]});
         chk(n >= 4, 1);
         chk(gie, 0);
         chk(stack_ptr, 16'hfffe);
         rd(`TPI_OFS_FLAGS, rv); chk(rv, 8'h00);
         if (i == 2) ev({2'b00, ev_t[i]});
         ret_seq();
         if (i == 2) begin wait_vec(); chk(v, vec_t[i]); ret_seq(); end
      end
      slow <= 1'b0; ev(5'b10000); wr(`TPI_OFS_IRQ_EN, 8'h00); wr(`TPI_OFS_PIN_EN, 8'hc0);
      for (p = 0; p < 2; p++) for (s = 0; s < 4; s++) begin
         wr(`TPI_OFS_SENSE, 8'(s) << (2 * p)); wr(`TPI_OFS_PIN_FLAGS, 8'hc0);
         for (e = 0; e < 2; e++) begin
            @(posedge clk); pin[p] <= e[0];
            repeat (6) @(posedge clk);
            rd(`TPI_OFS_PIN_FLAGS, rv); chk(rv & (8'h40 << p), (s == 2 + e) ? (8'h40 << p) : 8'h00);
            wr(`TPI_OFS_PIN_FLAGS, 8'hc0);
         end
      end
      wr(`TPI_OFS_SENSE, 8'h00); wr(`TPI_OFS_PIN_EN, 8'h40); ev(5'b01000);
      @(posedge clk); pin[0] <= 1'b0;
      wait_vec(); chk(v, `TPI_VEC_PIN_A);
      ret_seq(); wait_vec(); chk(v, `TPI_VEC_PIN_A);
      @(posedge clk); pin[0] <= 1'b1;
      repeat (4) @(posedge clk);
      ret_seq(); ev(5'b10000); wr(`TPI_OFS_FLAGS, 8'hff);
      ef = 8'h00; pe = 1'b0;
      repeat (300) begin
         lf = lfsr_next(lf);
         @(posedge clk); counter1 <= {12'h000, lf[3:0]}; capture_load <= &lf[5:4]; counter0_ovf <= &lf[7:6];
         ef = ef | {1'b0, lf[3:0] == 4'h5 && !pe, 2'b00, &lf[5:4], 1'b0, &lf[7:6], 1'b0};
         pe = (lf[3:0] == 4'h5);
      end
      @(posedge clk); capture_load <= 0; counter0_ovf <= 0; counter1 <= 16'h0006;
      rd(`TPI_OFS_FLAGS, rv); chk(rv, ef);
      close_out();
   end
endmodule
bind tpi_top tpi_props i_props(.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .insn_done(insn_done), .reti(reti), .pop_data(pop_data), .stack_ptr(stack_ptr),
   .pc_out(pc_out), .pc_load(pc_load), .core_ctl(core_ctl), .cpu_hold(cpu_hold), .gie(gie),
   .push_data(push_data), .pc_in(pc_in));
`default_nettype wire
